/* File: zs_cfg_map.svh */
// Register offsets, field positions, reset values and command codes
// ============================================================
// Summary of operation
// RULE1: Channel-select register at 0x12 picks front-end 0-15 for single work.
// RULE2: Sample-count register at 0x13 sets samples handled per trigger.
// RULE3: Zero sample count means derive count as (burst length + 1) * 3.
// RULE4: Software must not exceed delivered samples; experimental setting only.
// RULE5: Fixed mode threshold is threshold register times channel sigma.
// RULE6: Threshold register used only when config bit 4 set, else automatic.
// RULE7: Threshold: bits 13-8 integer, 7-2 fraction, 15-14 and 1-0 reserved.
// RULE8: Config at 0x15: bit 4 selects threshold source; bits 5,1 reserved.
// RULE9: Bit 3 suppresses nothing; bit 2 forces all pedestals to zero.
// RULE10: Bit 0 reduces each channel to peak sample and its position.
// RULE11: Memory holds pedestal and sigma per channel; calibration and host access.
// RULE12: Subaddress low part selects front-end input 0-15 for memory access.
// RULE13: Memory address bit 31 picks sigma (1) or pedestal (0); 30-8 reserved.
// RULE14: Address low byte is channel in transmission order, 0 to 127.
// RULE15: Each memory entry is an unsigned 12-bit value.
// RULE16: Command 0x0F bypasses processing; raw data from selected channel.
// RULE17: Command 0xFF resets processor and clears calibration success bits.
// RULE18: Reserved bits read as zero and ignore writes.
`ifndef ZS_CFG_MAP_SVH
`define ZS_CFG_MAP_SVH
// ============================================================
// Register offsets
`define ZS_OFF_CHSEL 8'h12
`define ZS_OFF_NSAMP 8'h13
`define ZS_OFF_THR 8'h14
`define ZS_OFF_CFG 8'h15
// ============================================================
// Field positions and masks
`define ZS_THR_MASK 16'h3FFC
`define ZS_CFG_MASK 6'h1D
`define ZS_CFG_THR_MODE 4
`define ZS_CFG_FORCE 3
`define ZS_CFG_NO_PED 2
`define ZS_CFG_PEAK 0
`define ZS_ADDR_SIGMA 31
`define ZS_FRAC_BITS 6
// ============================================================
// Reset values, constants and commands
`define ZS_RST_CHSEL 4'h0
`define ZS_RST_NSAMP 32'h0000_0000
`define ZS_RST_THR 16'h0000
`define ZS_RST_CFG 6'h00
`define ZS_AUTO_MULT 12'h0C0
`define ZS_NSAMP_MULT 32'h0000_0003
`define ZS_CMD_BYPASS 8'h0F
`define ZS_CMD_RESET 8'hFF
`endif

/* File: zs_cfg_pkg.sv */
// Types shared by the zero-suppression configuration block
package zs_cfg_pkg;
  typedef enum logic [1:0] {M_IDLE, M_READ, M_ACK, M_GAP} host_state_type;
  typedef logic [11:0] calib_word_type;
endpackage

/* File: calib_mem_if.sv */
// Carrier between the configuration block and one calibration table
`timescale 1ns/100ps
interface calib_mem_if #(parameter int AW = 11, parameter int DW = 12);
  logic a_we;
  logic a_en;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic b_en;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_rdata;
  modport mem (input a_we, a_en, a_addr, a_wdata, b_en, b_addr,
               output a_rdata, b_rdata);
  modport user (output a_we, a_en, a_addr, a_wdata, b_en, b_addr,
                input a_rdata, b_rdata);
endinterface

/* File: calib_mem.sv */
// Two-port calibration table with registered read data
`timescale 1ns/100ps
module calib_mem #(
  parameter int AW = 11,
  parameter int DW = 12
) (
  input wire logic clk_i,   // System clock
  calib_mem_if.mem port_m   // Access ports
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  // ============================================================
  // Port A read/write, port B read only; one entry per channel
  always_ff @(posedge clk_i) begin
    if (port_m.a_en && port_m.a_we) begin
      store[port_m.a_addr] <= port_m.a_wdata; // RULE11
    end
    if (port_m.a_en) begin
      port_m.a_rdata <= store[port_m.a_addr];
    end
    if (port_m.b_en) begin
      port_m.b_rdata <= store[port_m.b_addr];
    end
  end
endmodule // calib_mem

/* File: zs_threshold.sv */
// Threshold multiplier: sigma times fixed-point factor
`timescale 1ns/100ps
`include "zs_cfg_map.svh"
module zs_threshold #(
  parameter int DW = 12,
  parameter int MW = 12
) (
  input wire logic clk_i,            // System clock
  input wire logic [DW-1:0] sigma_i, // Channel sigma
  input wire logic [MW-1:0] mult_i,  // Multiplier, six fraction bits
  output logic [DW+MW-7:0] thr_o     // Integer threshold, registered
);
  logic [DW+MW-1:0] product;

  // Truncate fraction; rounding down keeps the threshold conservative
  assign product = (DW+MW)'(sigma_i) * (DW+MW)'(mult_i); // RULE5
  always_ff @(posedge clk_i) begin
    thr_o <= product[DW+MW-1:`ZS_FRAC_BITS];
  end
endmodule // zs_threshold

/* File: zs_config_regs.sv */
// Zero-suppression configuration registers and calibration memory port
`timescale 1ns/100ps
`include "zs_cfg_map.svh"
module zs_config_regs
  import zs_cfg_pkg::*;
#(
  parameter int FE_N = 16,
  parameter int BURST_W = 8
) (
  input wire logic CLK_I,               // 50 MHz clock
  input wire logic SYS_RST_I,           // Synchronous reset, high
  input wire logic [7:0] REG_ADDR_I,    // Register offset
  input wire logic [31:0] REG_WDATA_I,  // Register write data
  input wire logic REG_WE_I,            // Register write strobe
  input wire logic REG_RE_I,            // Register read strobe
  output logic [31:0] REG_RDATA_O,      // Register read data
  output logic REG_ACK_O,               // Register access done
  input wire logic [7:0] CMD_I,         // Processor command code
  input wire logic CMD_WE_I,            // Command write strobe
  input wire logic [BURST_W-1:0] BURST_LEN_I, // Trigger burst length n
  input wire logic MEM_REQ_I,           // Host memory request, level
  input wire logic MEM_WE_I,            // Host memory write
  input wire logic [3:0] MEM_SUB_I,     // Front-end selector
  input wire logic [31:0] MEM_ADDR_I,   // Memory address
  input wire logic [31:0] MEM_WDATA_I,  // Memory write data
  output logic [31:0] MEM_RDATA_O,      // Memory read data
  output logic MEM_ACK_O,               // Memory access done
  input wire logic CAL_WE_I,            // Calibration result write
  input wire logic CAL_SIGMA_I,         // Result is sigma
  input wire logic [3:0] CAL_FE_I,      // Result front-end
  input wire logic [6:0] CAL_CH_I,      // Result channel
  input wire logic [11:0] CAL_DATA_I,   // Result value
  input wire logic CAL_OK_I,            // Front-end calibrated, pulse
  input wire logic PROC_RD_I,           // Processor table lookup
  input wire logic [3:0] PROC_FE_I,     // Lookup front-end
  input wire logic [6:0] PROC_CH_I,     // Lookup channel
  output logic [11:0] PED_O,            // Pedestal for lookup
  output logic [17:0] THR_O,            // Threshold for lookup
  output logic PROC_VALID_O,            // Lookup result valid
  output logic [3:0] CHAN_SEL_O,        // Selected front-end
  output logic [31:0] SAMPLE_COUNT_O,   // Effective samples per trigger
  output logic THR_FIXED_O,             // Fixed threshold in use
  output logic FORCE_ALL_O,             // No channel suppressed
  output logic NO_PED_O,                // Pedestal correction off
  output logic PEAK_ONLY_O,             // Peak sample readout
  output logic BYPASS_O,                // Raw readout, one channel
  output logic PROC_RST_O,              // Processor reset pulse
  output logic [FE_N-1:0] CALIB_OK_O    // Calibration success per input
);
  // ============================================================
  // Register storage
  logic [3:0] calib_channel_select;
  logic [31:0] samples_per_trigger;
  logic [15:0] suppression_threshold;
  logic [5:0] suppression_config;
  logic bypass_mode;
  logic [FE_N-1:0] channel_calib_ok_bits;
  logic [31:0] reg_rdata;
  logic reg_ack;

  // Decode of register offsets
  wire hit_chsel = REG_ADDR_I == `ZS_OFF_CHSEL;
  wire hit_nsamp = REG_ADDR_I == `ZS_OFF_NSAMP;
  wire hit_thr = REG_ADDR_I == `ZS_OFF_THR;
  wire hit_cfg = REG_ADDR_I == `ZS_OFF_CFG;
  wire cmd_reset = CMD_WE_I && CMD_I == `ZS_CMD_RESET;
  wire cmd_bypass = CMD_WE_I && CMD_I == `ZS_CMD_BYPASS;

  // Read selection; reserved and unmapped bits read zero
  wire [31:0] next_rdata =
    hit_chsel ? {28'h000_0000, calib_channel_select} :
    hit_nsamp ? samples_per_trigger :
    hit_thr ? {16'h0000, suppression_threshold} :
    hit_cfg ? {26'h00_0000, suppression_config} : 32'h0000_0000;

  // ============================================================
  // Register writes; only 0-15 fit the selector, so upper bits drop
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      calib_channel_select <= `ZS_RST_CHSEL;
      samples_per_trigger <= `ZS_RST_NSAMP;
      suppression_threshold <= `ZS_RST_THR;
      suppression_config <= `ZS_RST_CFG;
    end else if (REG_WE_I) begin
      if (hit_chsel) calib_channel_select <= REG_WDATA_I[3:0]; // RULE1
      if (hit_nsamp) samples_per_trigger <= REG_WDATA_I; // RULE2
      if (hit_thr) begin
        suppression_threshold <= REG_WDATA_I[15:0] & `ZS_THR_MASK; // RULE7
      end
      if (hit_cfg) begin
        suppression_config <= REG_WDATA_I[5:0] & `ZS_CFG_MASK; // RULE18
      end
    end
  end

  // Read data and acknowledge one cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
    end else begin
      reg_rdata <= REG_RE_I ? next_rdata : reg_rdata;
      reg_ack <= REG_WE_I || REG_RE_I;
    end
  end
  assign REG_RDATA_O = reg_rdata;
  assign REG_ACK_O = reg_ack;

  // ============================================================
  // Commands: bypass holds until another command; reset is a pulse
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      bypass_mode <= 1'b0;
      PROC_RST_O <= 1'b0;
    end else begin
      if (CMD_WE_I) bypass_mode <= cmd_bypass; // RULE16
      PROC_RST_O <= cmd_reset; // RULE17
    end
  end

  // Success bits: a new success beats a simultaneous reset command
  genvar g;
  generate
    for (g = 0; g < FE_N; g++) begin : g_ok
      wire set_ok = CAL_OK_I && CAL_FE_I == 4'(g);
      always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
          channel_calib_ok_bits[g] <= 1'b0;
        end else if (set_ok) begin
          channel_calib_ok_bits[g] <= 1'b1;
        end else if (cmd_reset) begin
          channel_calib_ok_bits[g] <= 1'b0; // RULE17
        end
      end
    end
  endgenerate
  assign CALIB_OK_O = channel_calib_ok_bits;

  // ============================================================
  // Mode outputs taken straight from the configuration, select and bypass registers
  assign THR_FIXED_O = suppression_config[`ZS_CFG_THR_MODE]; // RULE6 RULE8
  assign FORCE_ALL_O = suppression_config[`ZS_CFG_FORCE]; // RULE9
  assign NO_PED_O = suppression_config[`ZS_CFG_NO_PED]; // RULE9
  assign PEAK_ONLY_O = suppression_config[`ZS_CFG_PEAK]; // RULE10
  assign BYPASS_O = bypass_mode;
  assign CHAN_SEL_O = calib_channel_select; // RULE1 RULE16

  // Zero count falls back to (trigger burst length + 1) * 3
  wire [31:0] derived_count =
    (32'(BURST_LEN_I) + 32'h0000_0001) * `ZS_NSAMP_MULT; // RULE3
  assign SAMPLE_COUNT_O = (samples_per_trigger == 32'h0000_0000) ?
    derived_count : samples_per_trigger; // RULE2 RULE3

  // ============================================================
  // Host access to the calibration tables
  host_state_type host_state;
  host_state_type next_host_state;
  logic host_sigma;
  logic host_ok;
  logic [31:0] mem_rdata;
  calib_mem_if #(.AW(11), .DW(12)) ped_bus ();
  calib_mem_if #(.AW(11), .DW(12)) sig_bus ();

  // Address decode; reserved address bits make the access a no-op
  wire addr_ok = MEM_ADDR_I[30:7] == 24'h00_0000; // RULE13 RULE14 RULE18
  wire addr_sigma = MEM_ADDR_I[`ZS_ADDR_SIGMA]; // RULE13
  wire [10:0] host_index = {MEM_SUB_I, MEM_ADDR_I[6:0]}; // RULE12 RULE14
  wire [10:0] cal_index = {CAL_FE_I, CAL_CH_I};
  // Calibration writes win the port; the host waits until CAL_WE_I drops
  wire host_take = host_state == M_IDLE && MEM_REQ_I && !CAL_WE_I;
  wire host_wr = host_take && MEM_WE_I && addr_ok;

  always_comb begin
    next_host_state = host_state;
    case (host_state)
      M_IDLE: if (host_take) next_host_state = M_READ;
      M_READ: next_host_state = M_ACK;
      M_ACK: next_host_state = M_GAP;
      M_GAP: next_host_state = M_IDLE;
      default: next_host_state = M_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      host_state <= M_IDLE;
      host_sigma <= 1'b0;
      host_ok <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      host_state <= next_host_state;
      if (host_take) host_sigma <= addr_sigma;
      if (host_take) host_ok <= addr_ok;
      if (host_state == M_READ) begin
        mem_rdata <= !host_ok ? 32'h0000_0000 : host_sigma ? // RULE18
          {20'h0_0000, sig_bus.a_rdata} : {20'h0_0000, ped_bus.a_rdata};
      end
    end
  end
  assign MEM_RDATA_O = mem_rdata; // RULE15
  assign MEM_ACK_O = host_state == M_ACK;

  // Port A: calibration result or host access; 12 bits kept
  assign ped_bus.a_en = CAL_WE_I || host_take;
  assign sig_bus.a_en = CAL_WE_I || host_take;
  assign ped_bus.a_we = CAL_WE_I ? !CAL_SIGMA_I : host_wr && !addr_sigma;
  assign sig_bus.a_we = CAL_WE_I ? CAL_SIGMA_I : host_wr && addr_sigma;
  assign ped_bus.a_addr = CAL_WE_I ? cal_index : host_index;
  assign sig_bus.a_addr = CAL_WE_I ? cal_index : host_index;
  assign ped_bus.a_wdata = CAL_WE_I ? CAL_DATA_I : MEM_WDATA_I[11:0]; // RULE15
  assign sig_bus.a_wdata = CAL_WE_I ? CAL_DATA_I : MEM_WDATA_I[11:0];

  // Port B: processor lookup of both tables at once
  assign ped_bus.b_en = PROC_RD_I;
  assign sig_bus.b_en = PROC_RD_I;
  assign ped_bus.b_addr = {PROC_FE_I, PROC_CH_I};
  assign sig_bus.b_addr = {PROC_FE_I, PROC_CH_I};

  calib_mem #(.AW(11), .DW(12)) u_ped_mem (.clk_i(CLK_I), .port_m(ped_bus));
  calib_mem #(.AW(11), .DW(12)) u_sig_mem (.clk_i(CLK_I), .port_m(sig_bus));

  // ============================================================
  // Lookup pipeline: table read, then pedestal and threshold
  logic [1:0] proc_pipe;
  logic [11:0] thr_mult;
  assign thr_mult = THR_FIXED_O ? suppression_threshold[13:2] :
    `ZS_AUTO_MULT; // RULE5 RULE6

  zs_threshold #(.DW(12), .MW(12)) u_thr (
    .clk_i(CLK_I),
    .sigma_i(sig_bus.b_rdata),
    .mult_i(thr_mult),
    .thr_o(THR_O)
  );

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      proc_pipe <= 2'b00;
      PED_O <= 12'h000;
    end else begin
      proc_pipe <= {proc_pipe[0], PROC_RD_I};
      PED_O <= NO_PED_O ? 12'h000 : ped_bus.b_rdata; // RULE9
    end
  end
  assign PROC_VALID_O = proc_pipe[1];

  // ============================================================
  // Checks beside the logic they guard
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_chsel_write: assert property ( // RULE1
    REG_WE_I && hit_chsel |=> CHAN_SEL_O == $past(REG_WDATA_I[3:0]))
    else $error("channel select not stored");
  a_count_derived: assert property ( // RULE3
    samples_per_trigger == 32'h0000_0000 |->
    SAMPLE_COUNT_O == (32'(BURST_LEN_I) + 32'h0000_0001) * 32'h0000_0003)
    else $error("derived sample count wrong");
  a_thr_reserved: assert property ( // RULE7
    suppression_threshold[15:14] == 2'b00 &&
    suppression_threshold[1:0] == 2'b00)
    else $error("threshold reserved bits set");
  a_cfg_reserved: assert property ( // RULE8
    REG_RE_I && hit_cfg |=> REG_RDATA_O[5] == 1'b0 && REG_RDATA_O[1] == 1'b0)
    else $error("config reserved bits read nonzero");
  a_ped_forced: assert property ( // RULE9
    NO_PED_O && $stable(suppression_config) && PROC_RD_I
    |-> ##2 PED_O == 12'h000)
    else $error("pedestal not forced to zero");
  a_ok_cleared: assert property ( // RULE17
    cmd_reset && !CAL_OK_I |=> CALIB_OK_O == 16'h0000)
    else $error("success bits survive reset command");
  a_bypass_mode: assert property ( // RULE16
    cmd_bypass |=> BYPASS_O throughout (!CMD_WE_I [*1] ##0 1'b1))
    else $error("bypass not entered");
  a_mem_ack: assert property ( // RULE11
    host_take |-> ##2 MEM_ACK_O ##1 !MEM_ACK_O)
    else $error("memory ack timing wrong");
  a_mem_width: assert property ( // RULE15
    MEM_ACK_O |-> MEM_RDATA_O[31:12] == 20'h0_0000)
    else $error("memory data wider than 12 bits");
  a_lookup_valid: assert property ( // RULE5
    PROC_RD_I |-> ##2 PROC_VALID_O)
    else $error("lookup result late");

  c_host_write: cover property (host_take && MEM_WE_I ##2 MEM_ACK_O);
  c_cal_collide: cover property (MEM_REQ_I && CAL_WE_I);
  c_bypass: cover property (cmd_bypass ##1 BYPASS_O);
  c_fixed_lookup: cover property (THR_FIXED_O && PROC_VALID_O);
endmodule // zs_config_regs

/* File: zero_suppression_config_calib_mem_bench.sv */
// Self-checking bench for the zero-suppression configuration block
`timescale 1ns/100ps
`include "zs_cfg_map.svh"
module zero_suppression_config_calib_mem_bench
  import zs_cfg_pkg::*;
;
  // ============================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, cmd = 8'h00, burst = 8'h04;
  logic [31:0] reg_wdata = 32'h0000_0000, mem_addr = 32'h0000_0000;
  logic [31:0] mem_wdata = 32'h0000_0000, reg_rdata, mem_rdata, sample_count;
  logic reg_we = 1'b0, reg_re = 1'b0, cmd_we = 1'b0, mem_req = 1'b0;
  logic mem_we = 1'b0, cal_we = 1'b0, cal_sigma = 1'b0, cal_ok = 1'b0;
  logic proc_rd = 1'b0, reg_ack, mem_ack, proc_valid, thr_fixed, force_all;
  logic no_ped, peak_only, bypass, proc_rst;
  logic [3:0] mem_sub = 4'h0, cal_fe = 4'h0, proc_fe = 4'h0, chan_sel;
  logic [6:0] cal_ch = 7'h00, proc_ch = 7'h00;
  logic [11:0] cal_data = 12'h000, ped;
  logic [17:0] thr;
  logic [15:0] calib_ok;
  logic [31:0] q;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  zs_config_regs DUT (.CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WE_I(reg_we), .REG_RE_I(reg_re),
    .REG_RDATA_O(reg_rdata), .REG_ACK_O(reg_ack), .CMD_I(cmd),
    .CMD_WE_I(cmd_we), .BURST_LEN_I(burst), .MEM_REQ_I(mem_req),
    .MEM_WE_I(mem_we), .MEM_SUB_I(mem_sub), .MEM_ADDR_I(mem_addr),
    .MEM_WDATA_I(mem_wdata), .MEM_RDATA_O(mem_rdata), .MEM_ACK_O(mem_ack),
    .CAL_WE_I(cal_we), .CAL_SIGMA_I(cal_sigma), .CAL_FE_I(cal_fe),
    .CAL_CH_I(cal_ch), .CAL_DATA_I(cal_data), .CAL_OK_I(cal_ok),
    .PROC_RD_I(proc_rd), .PROC_FE_I(proc_fe), .PROC_CH_I(proc_ch),
    .PED_O(ped), .THR_O(thr), .PROC_VALID_O(proc_valid),
    .CHAN_SEL_O(chan_sel), .SAMPLE_COUNT_O(sample_count),
    .THR_FIXED_O(thr_fixed), .FORCE_ALL_O(force_all), .NO_PED_O(no_ped),
    .PEAK_ONLY_O(peak_only), .BYPASS_O(bypass), .PROC_RST_O(proc_rst),
    .CALIB_OK_O(calib_ok));

  // ============================================================
  // Clock and hang guard; ceiling is far above the hundred or so cycles used
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ============================================================
  // Shared helpers
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access; the strobe is a single-cycle pulse
  task automatic reg_acc(input logic we, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    reg_addr = a;
    reg_wdata = d;
    reg_we = we;
    reg_re = !we;
    tick();
    reg_we = 1'b0;
    reg_re = 1'b0;
    check({31'h0, reg_ack}, 32'h0000_0001);
    r = reg_rdata;
    tick();
  endtask

  // Host memory access; request held until the acknowledge shows
  task automatic mem_acc(input logic we, input logic [3:0] s,
                         input logic [31:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    mem_we = we;
    mem_sub = s;
    mem_addr = a;
    mem_wdata = d;
    mem_req = 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while (mem_ack !== 1'b1 && n < 12);
    mem_req = 1'b0;
    check({31'h0, mem_ack}, 32'h0000_0001);
    r = mem_rdata;
    repeat (3) tick();
  endtask

  // Processor lookup; result is due two cycles after the take
  task automatic lookup(input logic [3:0] f, input logic [6:0] c);
    proc_fe = f;
    proc_ch = c;
    proc_rd = 1'b1;
    tick();
    proc_rd = 1'b0;
    tick();
    check({31'h0, proc_valid}, 32'h0000_0001);
  endtask

  task automatic command(input logic [7:0] c);
    cmd = c;
    cmd_we = 1'b1;
    tick();
    cmd_we = 1'b0;
  endtask

  // ============================================================
  // Scenarios
  task automatic test_reset();
    reg_acc(1'b0, `ZS_OFF_CHSEL, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    reg_acc(1'b0, `ZS_OFF_CFG, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    check(sample_count, 32'h0000_000F);
    check({16'h0, calib_ok}, 32'h0000_0000);
    check({31'h0, bypass}, 32'h0000_0000);
  endtask

  task automatic test_regs();
    reg_acc(1'b1, `ZS_OFF_CHSEL, 32'h0000_000F, q);
    reg_acc(1'b0, `ZS_OFF_CHSEL, 32'h0000_0000, q);
    check(q, 32'h0000_000F);
    check({28'h0, chan_sel}, 32'h0000_000F);
    reg_acc(1'b1, `ZS_OFF_NSAMP, 32'h0000_0007, q);
    check(sample_count, 32'h0000_0007);
    reg_acc(1'b1, `ZS_OFF_NSAMP, 32'h0000_0000, q);
    burst = 8'h09;
    #1 check(sample_count, 32'h0000_001E);
    reg_acc(1'b1, `ZS_OFF_THR, 32'hFFFF_FFFF, q);
    reg_acc(1'b0, `ZS_OFF_THR, 32'h0000_0000, q);
    check(q, 32'h0000_3FFC);
    reg_acc(1'b1, `ZS_OFF_CFG, 32'hFFFF_FFFF, q);
    reg_acc(1'b0, `ZS_OFF_CFG, 32'h0000_0000, q);
    check(q, 32'h0000_001D);
    check({28'h0, thr_fixed, force_all, no_ped, peak_only},
          32'h0000_000F);
    reg_acc(1'b1, `ZS_OFF_CFG, 32'h0000_0000, q);
    check({28'h0, thr_fixed, force_all, no_ped, peak_only},
          32'h0000_0000);
    reg_acc(1'b0, 8'h16, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
  endtask

  // Calibration write, host writes to both tables, input selection and lookups
  task automatic test_mem();
    cal_we = 1'b1;
    cal_sigma = 1'b1;
    cal_fe = 4'h2;
    cal_ch = 7'h05;
    cal_data = 12'h0A5;
    tick();
    cal_we = 1'b0;
    mem_acc(1'b0, 4'h2, 32'h8000_0005, 32'h0000_0000, q);
    check(q, 32'h0000_00A5);
    mem_acc(1'b1, 4'h2, 32'h0000_0005, 32'hFFFF_F123, q);
    mem_acc(1'b1, 4'h3, 32'h0000_0005, 32'h0000_0456, q);
    mem_acc(1'b1, 4'h2, 32'h0000_0105, 32'h0000_0777, q);
    mem_acc(1'b0, 4'h2, 32'h0000_0005, 32'h0000_0000, q);
    check(q, 32'h0000_0123);
    mem_acc(1'b0, 4'h3, 32'h0000_0005, 32'h0000_0000, q);
    check(q, 32'h0000_0456);
    mem_acc(1'b0, 4'h3, 32'h0000_0105, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    mem_acc(1'b1, 4'hF, 32'h8000_007F, 32'h0000_0ABC, q);
    mem_acc(1'b0, 4'hF, 32'h8000_007F, 32'h0000_0000, q);
    check(q, 32'h0000_0ABC);
    lookup(4'h2, 7'h05);
    check({20'h0, ped}, 32'h0000_0123);
    check({14'h0, thr}, 32'h0000_01EF);
    reg_acc(1'b1, `ZS_OFF_THR, 32'h0000_0144, q);
    reg_acc(1'b1, `ZS_OFF_CFG, 32'h0000_0014, q);
    lookup(4'h2, 7'h05);
    check({14'h0, thr}, 32'h0000_00D0);
    check({20'h0, ped}, 32'h0000_0000);
  endtask

  // Success bits, bypass mode and processor reset
  task automatic test_cmd();
    cal_fe = 4'h6;
    cal_ok = 1'b1;
    tick();
    cal_ok = 1'b0;
    tick();
    check({16'h0, calib_ok}, 32'h0000_0040);
    command(`ZS_CMD_BYPASS);
    check({31'h0, bypass}, 32'h0000_0001);
    tick();
    command(8'h01);
    check({31'h0, bypass}, 32'h0000_0000);
    tick();
    command(`ZS_CMD_RESET);
    check({31'h0, proc_rst}, 32'h0000_0001);
    tick();
    check({16'h0, calib_ok}, 32'h0000_0000);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    tick();
    test_reset();
    test_regs();
    test_mem();
    test_cmd();
    tally_and_finish();
  end
endmodule // zero_suppression_config_calib_mem_bench
